/* File: rtl/anti_tearing_write_control.sv */
// anti-tearing write controller: command decode, buffer staging and commit
`timescale 1ns/1ps
// Functional notes
// RULE_01: anti-tearing writes carry at most eight data bytes, longer ones refused.
// RULE_02: anti-tearing response takes about four times a normal write.
// RULE_03: set-user-zone with select bit one turns buffered user writes on.
// RULE_04: set-user-zone with select bit zero turns direct user writes back on.
// RULE_05: parameter byte: bit 7 select, bits 6-4 zero, bits 3-0 zone.
// RULE_06: system-zone parameter 80h writes configuration through the buffer.
// RULE_07: system-zone parameter 00h writes configuration directly.
// RULE_08: parameter 01h is a one-byte fuse write; other values refused.
// RULE_09: length field is count minus one; that many plus one bytes follow.
// RULE_10: configuration anti-tearing only on the capable variant family.
// RULE_11: all anti-tearing writes staged in one shared buffer first.
// RULE_12: buffer, set flag, copy to target, clear flag, then acknowledge.
// RULE_13: at power-up a set flag forces completion before any command.
module anti_tearing_write_control
  import tear_pkg::*;
#(
  parameter bit SYS_TEAR_CAPABLE = 1'b1
)(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire cmd_s       cmd,
  input  wire logic       data_valid,
  input  wire logic [7:0] data_byte,
  output logic            rsp_valid,
  output logic            rsp_ack,
  output logic [3:0]      zone_q,
  output logic            tear_sel_q,
  output logic            buf_wr,
  output logic            flag_wr,
  output logic            flag_val,
  output logic            tgt_wr,
  output logic            fuse_wr,
  output mem_wr_s         mem_wr_q,
  output logic            tgt_is_sys_q,
  input  wire logic       mem_done,
  input  wire logic       flag_stored,
  input  wire logic [7:0] buf_rd_data,
  output logic [2:0]      buf_idx_q
);

  typedef enum logic [3:0] {
    S_POR, S_IDLE, S_RECV, S_DIRECT, S_BUF, S_FLAG_SET, S_COPY, S_FLAG_CLR, S_RESP
  } state_e;

  state_e      state_q;
  logic [4:0]  cnt_q;
  logic [4:0]  len_q;
  logic [7:0]  base_q;
  logic        tear_q;
  logic        fuse_q;
  logic        ack_q;
  logic        recover_q;
  logic [7:0]  data_mem [MAX_LEN];
  logic        accept;
  logic        bad_cmd;
  logic        use_tear;

  assign cmd_ready = (state_q == S_IDLE); // see RULE_13
  assign accept    = cmd_valid && cmd_ready;

  always_comb
  begin
    use_tear = 1'b0;
    bad_cmd  = 1'b0;
    unique case (cmd.kind)
      CMD_WRITE_USER:
      begin
        use_tear = tear_sel_q; // see RULE_03
        bad_cmd  = tear_sel_q && (cmd.len_m1 >= 5'(TEAR_MAX_BYTES)); // see RULE_01
      end
      CMD_WRITE_SYS:
      begin
        if (cmd.command_parameter_byte == SYS_MODE_TEAR)
        begin
          use_tear = SYS_TEAR_CAPABLE; // see RULE_06
          bad_cmd  = !SYS_TEAR_CAPABLE || (cmd.len_m1 >= 5'(TEAR_MAX_BYTES)); // see RULE_10
        end
        else if (cmd.command_parameter_byte == SYS_MODE_FUSE)
          bad_cmd = (cmd.len_m1 != 5'h00); // see RULE_08
        else if (cmd.command_parameter_byte != SYS_MODE_NORMAL)
          bad_cmd = 1'b1; // see RULE_07 see RULE_08
      end
      CMD_SET_ZONE:
        bad_cmd = (cmd.command_parameter_byte[PAD_MSB:PAD_LSB] != 3'h0); // see RULE_05
      default:
        bad_cmd = 1'b1;
    endcase
  end

  // zone and tear select state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      zone_q     <= ZONE_RESET;
      tear_sel_q <= 1'b0;
    end
    else if (accept && cmd.kind == CMD_SET_ZONE && !bad_cmd)
    begin
      tear_sel_q <= cmd.command_parameter_byte[SEL_BIT_POS]; // see RULE_03 see RULE_04
      zone_q     <= cmd.command_parameter_byte[ZONE_MSB:ZONE_LSB]; // see RULE_05
    end
  end

  // main sequencer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= S_POR;
      cnt_q        <= 5'h00;
      len_q        <= 5'h00;
      base_q       <= 8'h00;
      tear_q       <= 1'b0;
      fuse_q       <= 1'b0;
      ack_q        <= 1'b0;
      tgt_is_sys_q <= 1'b0;
      buf_idx_q    <= 3'h0;
      recover_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        S_POR:
          if (flag_stored)
          begin
            tear_q    <= 1'b1;
            cnt_q     <= 5'h00;
            buf_idx_q <= 3'h0;
            recover_q <= 1'b1;
            state_q   <= S_COPY; // see RULE_13
          end
          else
            state_q <= S_IDLE;
        S_IDLE:
          if (accept)
          begin
            cnt_q        <= 5'h00;
            len_q        <= cmd.len_m1; // see RULE_09
            base_q       <= cmd.addr;
            tear_q       <= use_tear;
            fuse_q       <= (cmd.kind == CMD_WRITE_SYS) &&
                            (cmd.command_parameter_byte == SYS_MODE_FUSE);
            tgt_is_sys_q <= (cmd.kind == CMD_WRITE_SYS);
            if (bad_cmd || cmd.kind == CMD_SET_ZONE)
            begin
              ack_q   <= !bad_cmd;
              state_q <= S_RESP;
            end
            else
              state_q <= S_RECV;
          end
        S_RECV:
          if (data_valid)
          begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == len_q)
            begin
              cnt_q   <= 5'h00;
              state_q <= tear_q ? S_BUF : S_DIRECT; // see RULE_11
            end
          end
        S_DIRECT, S_BUF, S_COPY:
          if (mem_done)
          begin
            cnt_q     <= cnt_q + 5'h01;
            buf_idx_q <= cnt_q[2:0] + 3'h1;
            if (cnt_q == len_q)
            begin
              cnt_q     <= 5'h00;
              buf_idx_q <= 3'h0;
              ack_q     <= 1'b1;
              unique case (state_q)
                S_BUF:   state_q <= S_FLAG_SET; // see RULE_12
                S_COPY:  state_q <= S_FLAG_CLR;
                default: state_q <= S_RESP;
              endcase
            end
          end
        S_FLAG_SET:
          if (mem_done)
            state_q <= S_COPY; // see RULE_12
        S_FLAG_CLR:
          if (mem_done)
          begin
            recover_q <= 1'b0;
            state_q   <= recover_q ? S_IDLE : S_RESP; // see RULE_13
          end
        S_RESP:
        begin
          tear_q  <= 1'b0;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // incoming data capture
  always_ff @(posedge ref_clk)
  begin
    if (state_q == S_RECV && data_valid)
      data_mem[cnt_q] <= data_byte;
  end

  // memory write data, a one-byte buffered write takes four memory steps (buffer, flag set, copy, flag clear) (see RULE_02)
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mem_wr_q <= '0;
    else if (state_q == S_COPY)
      mem_wr_q <= '{addr: base_q + 8'(cnt_q), data: buf_rd_data}; // see RULE_12
    else
      mem_wr_q <= '{addr: base_q + 8'(cnt_q), data: data_mem[cnt_q]};
  end

  assign buf_wr    = (state_q == S_BUF);
  assign flag_wr   = (state_q == S_FLAG_SET) || (state_q == S_FLAG_CLR);
  assign flag_val  = (state_q == S_FLAG_SET);
  assign tgt_wr    = ((state_q == S_DIRECT) && !fuse_q) || (state_q == S_COPY);
  assign fuse_wr   = (state_q == S_DIRECT) && fuse_q;
  assign rsp_valid = (state_q == S_RESP);
  assign rsp_ack   = (state_q == S_RESP) && ack_q;

endmodule

/* File: rtl/tear_pkg.sv */
// shared constants and types for the anti-tearing write controller
package tear_pkg;
  localparam int          TEAR_MAX_BYTES     = 8;
  localparam logic [7:0]  SYS_MODE_NORMAL    = 8'h00;
  localparam logic [7:0]  SYS_MODE_TEAR      = 8'h80;
  localparam logic [7:0]  SYS_MODE_FUSE      = 8'h01;
  localparam int          SEL_BIT_POS        = 7;
  localparam int          ZONE_LSB           = 0;
  localparam int          ZONE_MSB           = 3;
  localparam int          PAD_LSB            = 4;
  localparam int          PAD_MSB            = 6;
  localparam int          TIME_SCALE         = 4;
  localparam int          ENDURANCE_MIN      = 50000;
  localparam logic [3:0]  ZONE_RESET         = 4'h0;
  localparam int          MAX_LEN            = 32;

  typedef enum logic [1:0] {CMD_SET_ZONE, CMD_WRITE_USER, CMD_WRITE_SYS} cmd_kind_e;

  typedef struct packed {
    cmd_kind_e  kind;
    logic [7:0] command_parameter_byte;
    logic [7:0] addr;
    logic [4:0] len_m1;
  } cmd_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mem_wr_s;
endpackage

/* File: tb/anti_tearing_write_control_tb_top.sv */
// self-checking bench for the anti-tearing write controller
`timescale 1ns/1ps
module anti_tearing_write_control_tb_top;
  import tear_pkg::*;
  typedef struct packed {cmd_kind_e k; logic [7:0] p; logic [4:0] l; logic a;
                         logic [2:0] m;} row_s;
  logic ref_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, data_valid = 1'b0, seen;
  logic [7:0] data_byte = 8'h00, buf_rd_data;
  cmd_s cmd = '0;
  logic cmd_ready, rsp_valid, rsp_ack, tear_sel_q, buf_wr, flag_wr, flag_val, tgt_wr, fuse_wr;
  logic mem_done, flag_stored, tgt_is_sys_q;
  logic rsp_seen, nc_rsp_valid, nc_rsp_ack;
  logic [1:0] nc_got;
  logic [3:0] zone_q;
  logic [2:0] buf_idx_q;
  mem_wr_s mem_wr_q;
  int error_cnt = 0, tests_run = 0, cyc, cn;
  row_s rows [13] = '{'{CMD_SET_ZONE, 8'h83, 5'h00, 1'b1, 3'h0},
    '{CMD_WRITE_USER, 8'h00, 5'h00, 1'b1, 3'h6}, '{CMD_WRITE_USER, 8'h00, 5'h07, 1'b1, 3'h6},
    '{CMD_WRITE_USER, 8'h00, 5'h08, 1'b0, 3'h0}, '{CMD_WRITE_SYS, 8'h80, 5'h07, 1'b1, 3'h6},
    '{CMD_WRITE_SYS, 8'h80, 5'h08, 1'b0, 3'h0}, '{CMD_WRITE_SYS, 8'h00, 5'h0F, 1'b1, 3'h2},
    '{CMD_WRITE_SYS, 8'h01, 5'h00, 1'b1, 3'h1}, '{CMD_WRITE_SYS, 8'h01, 5'h01, 1'b0, 3'h0},
    '{CMD_WRITE_SYS, 8'h02, 5'h00, 1'b0, 3'h0}, '{CMD_SET_ZONE, 8'h90, 5'h00, 1'b0, 3'h0},
    '{CMD_SET_ZONE, 8'h02, 5'h00, 1'b1, 3'h0}, '{CMD_WRITE_USER, 8'h00, 5'h0F, 1'b1, 3'h2}};
  anti_tearing_write_control #(.SYS_TEAR_CAPABLE(1'b1)) dut_u (.*);
  tear_mem_model #(.FLAG_INIT(1'b1)) mem_u (.*);
  anti_tearing_write_control #(.SYS_TEAR_CAPABLE(1'b0)) nc_dut_u (.ref_clk, .rst, .cmd_valid,
    .cmd_ready(), .cmd, .data_valid, .data_byte, .rsp_valid(nc_rsp_valid),
    .rsp_ack(nc_rsp_ack), .zone_q(), .tear_sel_q(), .buf_wr(), .flag_wr(), .flag_val(),
    .tgt_wr(), .fuse_wr(), .mem_wr_q(), .tgt_is_sys_q(), .mem_done, .flag_stored,
    .buf_rd_data, .buf_idx_q());
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("FAIL %0t got %h expected %h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic run(input row_s r, output int n);
    int i;
    logic [2:0] m;
    m = 3'h0;
    nc_got = 2'h0;
    cmd = '{r.k, r.p, 8'h10, r.l};
    for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    for (i = 0; i < 300 && rsp_valid !== 1'b1; i++)
    begin
      cmd_valid = 1'b0;
      data_valid = r.a && i <= r.l;
      data_byte = 8'hA0 + i[7:0];
      m |= {buf_wr, tgt_wr, fuse_wr};
      if (nc_rsp_valid)
        nc_got = {1'b1, nc_rsp_ack};
      if (mem_done && !flag_wr)
        chk(mem_wr_q.data, 8'hA0 + mem_wr_q.addr - 8'h10);
      @(negedge ref_clk);
    end
    cmd_valid = 1'b0;
    data_valid = 1'b0;
    n = i;
    chk({rsp_valid, rsp_ack}, {1'b1, r.a});
    chk(m, r.m);
    @(negedge ref_clk);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge ref_clk);
    chk({rsp_valid, tear_sel_q, zone_q == ZONE_RESET}, 8'h01);
    rst = 1'b0;
    seen = 1'b0;
    rsp_seen = 1'b0;
    for (cn = 0; cn < 300 && cmd_ready !== 1'b1; cn++)
    begin
      seen |= tgt_wr;
      rsp_seen |= rsp_valid;
      @(negedge ref_clk);
    end
    chk({seen, flag_stored, rsp_seen}, 8'h04);
    foreach (rows[j]) run(rows[j], cyc);
    run('{CMD_WRITE_SYS, 8'h80, 5'h00, 1'b1, 3'h6}, cn);
    chk(nc_got, 8'h02);
    run('{CMD_SET_ZONE, 8'h81, 5'h00, 1'b1, 3'h0}, cyc);
    chk({tear_sel_q, zone_q}, 8'h11);
    run('{CMD_WRITE_USER, 8'h00, 5'h00, 1'b1, 3'h6}, cyc);
    run('{CMD_SET_ZONE, 8'h01, 5'h00, 1'b1, 3'h0}, cn);
    chk(tear_sel_q, 1'b0);
    run('{CMD_WRITE_USER, 8'h00, 5'h00, 1'b1, 3'h2}, cn);
    chk(cyc - 1 == TIME_SCALE * (cn - 1), 1'b1);
    run('{CMD_SET_ZONE, 8'h85, 5'h00, 1'b1, 3'h0}, cn);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({cmd_ready, rsp_valid, tear_sel_q, zone_q}, 8'h40);
    final_report();
  end
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule

/* File: tb/tear_mem_model.sv */
// self-timed memory and stored flag beside the controller
`timescale 1ns/1ps
module tear_mem_model
  import tear_pkg::*;
#(
  parameter bit FLAG_INIT = 1'b1
)(
  input  wire logic       ref_clk,
  input  wire logic       buf_wr,
  input  wire logic       flag_wr,
  input  wire logic       flag_val,
  input  wire logic       tgt_wr,
  input  wire logic       fuse_wr,
  input  wire mem_wr_s    mem_wr_q,
  input  wire logic [2:0] buf_idx_q,
  output logic            mem_done,
  output logic            flag_stored,
  output logic [7:0]      buf_rd_data
);
  logic [1:0] cnt_q = 2'h0;
  logic       fl_q = FLAG_INIT;
  logic [7:0] mem_q [8] = '{default: 8'h00};
  assign mem_done = cnt_q == 2'h2;
  assign flag_stored = fl_q;
  assign buf_rd_data = mem_q[buf_idx_q];
  always_ff @(posedge ref_clk)
  begin
    cnt_q <= ((buf_wr | flag_wr | tgt_wr | fuse_wr) && !mem_done) ? cnt_q + 2'h1 : 2'h0;
    if (mem_done && flag_wr)
      fl_q <= flag_val;
    if (mem_done && buf_wr)
      mem_q[mem_wr_q.addr[2:0]] <= mem_wr_q.data;
  end
endmodule

/* File: tb/tear_monitor.sv */
// checker for the anti-tearing write controller
`timescale 1ns/1ps
module tear_monitor
  import tear_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire cmd_s cmd,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic tear_sel_q,
  input wire logic buf_wr,
  input wire logic flag_wr,
  input wire logic flag_val,
  input wire logic tgt_wr,
  input wire logic mem_done
);
  logic       tk, dt, b_q, f_q, t_q, c_q, d_q;
  logic [7:0] p;
  assign tk = cmd_valid && cmd_ready;
  assign p = cmd.command_parameter_byte;
  assign dt = tk && (cmd.kind == CMD_WRITE_USER ? !tear_sel_q : cmd.kind == CMD_WRITE_SYS && !p);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // completed memory steps and direct-write acceptance of the current command
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {b_q, f_q, t_q, c_q, d_q} <= '0;
    else if (rsp_valid)
      {b_q, f_q, t_q, c_q, d_q} <= '0;
    else
    begin
      b_q <= b_q | (buf_wr & mem_done);
      f_q <= f_q | (flag_wr & flag_val & mem_done);
      t_q <= t_q | (tgt_wr & mem_done);
      c_q <= c_q | (flag_wr & ~flag_val & mem_done & t_q);
      d_q <= d_q | dt;
    end
  chk_pad_refuse: assert property (
    tk && cmd.kind == CMD_SET_ZONE && p[6:4] != 3'h0 |=> rsp_valid && !rsp_ack) else $error("pad");
  chk_sel_follow: assert property (
    tk && cmd.kind == CMD_SET_ZONE && p[6:4] == 3'h0 |-> ##2 tear_sel_q == $past(p[7], 2))
    else $error("select not taken");
  chk_long_refuse: assert property (
    tk && cmd.kind == CMD_WRITE_USER && tear_sel_q && cmd.len_m1 > 5'h7 |=> rsp_valid && !rsp_ack)
    else $error("long write taken");
  chk_sys_refuse: assert property (
    tk && cmd.kind == CMD_WRITE_SYS && (!(p inside {8'h00, 8'h80, 8'h01})
    || p == 8'h01 && cmd.len_m1 != 5'h0 || p == 8'h80 && cmd.len_m1 > 5'h7)
    |=> rsp_valid && !rsp_ack) else $error("bad system write taken");
  chk_flag_order: assert property (flag_wr && flag_val |-> b_q)
    else $error("flag before buffer");
  chk_copy_order: assert property (tgt_wr && b_q |-> f_q)
    else $error("copy before flag");
  chk_ack_order: assert property (rsp_valid && rsp_ack && b_q |-> c_q)
    else $error("ack before flag clear");
  chk_direct_path: assert property (d_q |-> !buf_wr && !flag_wr)
    else $error("direct write buffered");
  cover property (rsp_valid && rsp_ack && c_q);
  cover property (rsp_valid && !rsp_ack);
  cover property (d_q && rsp_valid);
endmodule
bind anti_tearing_write_control tear_monitor mon_u (.*);
